/* pkg/irq_regs_pkg.sv */
// constants for the peripheral interrupt flag and enable register slice
package irq_regs_pkg;

  // ****************************************
  // bus geometry
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_TIMER_FLAGS = 8'h00;
  localparam logic [7:0] OFF_ENABLE_FIRST = 8'h04;
  localparam logic [7:0] OFF_ENABLE_SECOND = 8'h08;
  localparam logic [7:0] OFF_TIMER_ENABLE = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

  // ****************************************
  // field widths and positions
  // ****************************************
  localparam int TFLAG_W = 3;
  localparam int TIMER_FOUR_BIT = 0;
  localparam int TIMER_FIVE_BIT = 1;
  localparam int TIMER_SIX_BIT = 2;
  localparam int EN1_W = 7;
  localparam int EN2_W = 8;
  localparam int TIMER_CNT_W = 8;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [2:0] RST_TIMER_FLAGS = 3'h0;
  localparam logic [6:0] RST_ENABLE_FIRST = 7'h00;
  localparam logic [7:0] RST_ENABLE_SECOND = 8'h00;
  localparam logic [2:0] RST_TIMER_ENABLE = 3'h0;
  localparam logic [2:0] RST_IRQ_STATUS = 3'h0;
  localparam logic [2:0] RST_IRQ_MASK = 3'h0;

  // ****************************************
  // bus responses
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : irq_regs_pkg

/* rtl/event_flag_bank.sv */
// sticky flag bank: load, clear and set per bit, set always wins
`timescale 1ns/10ps
module event_flag_bank #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic mclk, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic ce, // clock enable
  input wire logic ld_en, // software load of the whole bank
  input wire logic [W-1:0] ld_data, // value loaded by software
  input wire logic [W-1:0] clr, // bits to clear this cycle
  input wire logic [W-1:0] set, // hardware events this cycle
  output logic [W-1:0] q // flag state
);

  // ****************************************
  // one flop per flag
  // ****************************************
  for (genvar i = 0; i < W; i++) begin : g_flag
    logic flag_nxt;
    // an event in the clearing cycle is kept: set is applied last
    assign flag_nxt = ((ld_en ? ld_data[i] : q[i]) & ~clr[i]) | set[i];
    always_ff @(posedge mclk) begin
      if (rst) begin
        q[i] <= RST_VAL[i];
      end else if (ce) begin
        q[i] <= flag_nxt;
      end
    end
  end

endmodule : event_flag_bank

/* rtl/axil_slave_port.sv */
// axi4-lite slave front end: one write and one read in flight
`timescale 1ns/10ps
module axil_slave_port
  import irq_regs_pkg::*;
(
  input wire logic mclk, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic ce, // clock enable
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [irq_regs_pkg::ADDR_W-1:0] awaddr, // write address
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  input wire logic [irq_regs_pkg::DATA_W-1:0] wdata, // write data
  input wire logic [irq_regs_pkg::STRB_W-1:0] wstrb, // byte strobes
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  output logic [1:0] bresp, // write response
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  input wire logic [irq_regs_pkg::ADDR_W-1:0] araddr, // read address
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic [irq_regs_pkg::DATA_W-1:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic wr_en, // register write pulse
  output logic [irq_regs_pkg::ADDR_W-1:0] wr_addr, // register write address
  output logic [irq_regs_pkg::DATA_W-1:0] wr_data, // register write data
  output logic [irq_regs_pkg::STRB_W-1:0] wr_strb, // register write strobes
  input wire logic [1:0] wr_resp, // response for wr_addr
  output logic rd_en, // register read pulse
  input wire logic [irq_regs_pkg::DATA_W-1:0] rd_data, // data at araddr
  input wire logic [1:0] rd_resp // response for araddr
);

  logic aw_held_r;
  logic w_held_r;
  logic aw_take;
  logic w_take;

  // ****************************************
  // handshake terms
  // ****************************************
  assign aw_take = ce & awvalid & awready;
  assign w_take = ce & wvalid & wready;
  assign wr_en = ce & aw_held_r & w_held_r & ~bvalid;
  assign rd_en = ce & arvalid & arready;

  // write side: address and data caught in either order
  // ready lives in a flop so the bus sees no combinational path out
  always_ff @(posedge mclk) begin
    if (rst) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (ce) begin
      if (aw_take) begin
        aw_held_r <= 1'b1;
        awready <= 1'b0;
        wr_addr <= awaddr;
      end
      if (w_take) begin
        w_held_r <= 1'b1;
        wready <= 1'b0;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (wr_en) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_resp;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // read side: data latched on the accepting edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (ce) begin
      if (rd_en) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_data;
        rresp <= rd_resp;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule : axil_slave_port

/* rtl/peripheral_irq_flag_enable_regs.sv */
// timer event flags, peripheral enables and the peripheral request
//
// Operation
// - timer six period match sets flag bit 2
// - timer five overflow sets flag bit 1
// - timer four period match sets flag bit 0
// - flag bits 7..3 unstored, read zero
// - first enable register, bit 7 reads zero
// - second enable register, eight enable bits
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
module peripheral_irq_flag_enable_regs
  import irq_regs_pkg::*;
#(
  parameter int CNT_W = irq_regs_pkg::TIMER_CNT_W
) (
  input wire logic mclk, // system clock, 125 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic ce, // clock enable, freezes all state
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [irq_regs_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  input wire logic [irq_regs_pkg::DATA_W-1:0] s_axi_wdata, // write data
  input wire logic [irq_regs_pkg::STRB_W-1:0] s_axi_wstrb, // write strobes
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  output logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  input wire logic [irq_regs_pkg::ADDR_W-1:0] s_axi_araddr, // read address
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic [irq_regs_pkg::DATA_W-1:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  input wire logic [CNT_W-1:0] timer_four_count, // fourth timer count
  input wire logic [CNT_W-1:0] timer_four_period, // fourth timer period
  input wire logic timer_five_overflow, // fifth timer overflow pulse
  input wire logic [CNT_W-1:0] timer_six_count, // sixth timer count
  input wire logic [CNT_W-1:0] timer_six_period, // sixth timer period
  input wire logic [irq_regs_pkg::EN1_W-1:0] first_src_flags, // flags gated by first enables
  input wire logic [irq_regs_pkg::EN2_W-1:0] second_src_flags, // flags gated by second enables
  output logic periph_irq_req, // request toward the cpu
  output logic irq // unmasked status interrupt
);

  // ****************************************
  // internal signals
  // ****************************************
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [STRB_W-1:0] wr_strb;
  logic [1:0] wr_resp;
  logic rd_en;
  logic [DATA_W-1:0] rd_data;
  logic [1:0] rd_resp;

  logic wr_lane0;
  logic wr_hit_flags;
  logic wr_hit_en1;
  logic wr_hit_en2;
  logic wr_hit_ten;
  logic wr_hit_status;
  logic wr_hit_mask;
  logic wr_mapped;

  logic rd_hit_flags;
  logic rd_hit_en1;
  logic rd_hit_en2;
  logic rd_hit_ten;
  logic rd_hit_status;
  logic rd_hit_mask;
  logic rd_mapped;

  logic four_match;
  logic six_match;
  logic four_match_d_r;
  logic six_match_d_r;
  logic [TFLAG_W-1:0] timer_events;
  logic [TFLAG_W-1:0] status_clr;

  logic [TFLAG_W-1:0] timer_flags;
  logic [TFLAG_W-1:0] irq_status;
  logic [EN1_W-1:0] en1_r;
  logic [EN1_W-1:0] en1_nxt;
  logic [EN2_W-1:0] en2_r;
  logic [EN2_W-1:0] en2_nxt;
  logic [TFLAG_W-1:0] ten_r;
  logic [TFLAG_W-1:0] ten_nxt;
  logic [TFLAG_W-1:0] mask_r;
  logic [TFLAG_W-1:0] mask_nxt;

  logic timer_six_match_flag;
  logic timer_five_overflow_flag;
  logic timer_four_match_flag;

  logic converter_irq_enable;
  logic serial_one_receive_enable;
  logic serial_one_transmit_enable;
  logic sync_port_one_enable;
  logic capture_one_enable;
  logic timer_two_match_enable;
  logic timer_one_overflow_enable;

  logic osc_fail_enable;
  logic comparator_one_enable;
  logic comparator_two_enable;
  logic eeprom_write_done_enable;
  logic bus_collision_one_enable;
  logic voltage_detect_enable;
  logic timer_three_overflow_enable;
  logic capture_two_enable;

  logic [TFLAG_W-1:0] timer_req;
  logic [EN1_W-1:0] first_req;
  logic [EN2_W-1:0] second_req;
  logic req_any;
  logic irq_any;

  // ****************************************
  // bus front end
  // ****************************************
  axil_slave_port u_bus (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .awaddr(s_axi_awaddr),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .bresp(s_axi_bresp),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .araddr(s_axi_araddr),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_resp(wr_resp),
    .rd_en(rd_en),
    .rd_data(rd_data),
    .rd_resp(rd_resp)
  );

  // ****************************************
  // address decode
  // ****************************************
  // all fields sit in byte lane 0, other lanes are don't care
  assign wr_lane0 = wr_en & wr_strb[0];
  assign wr_hit_flags = wr_addr == OFF_TIMER_FLAGS;
  assign wr_hit_en1 = wr_addr == OFF_ENABLE_FIRST;
  assign wr_hit_en2 = wr_addr == OFF_ENABLE_SECOND;
  assign wr_hit_ten = wr_addr == OFF_TIMER_ENABLE;
  assign wr_hit_status = wr_addr == OFF_IRQ_STATUS;
  assign wr_hit_mask = wr_addr == OFF_IRQ_MASK;
  assign wr_mapped = wr_hit_flags | wr_hit_en1 | wr_hit_en2 |
                     wr_hit_ten | wr_hit_status | wr_hit_mask;
  assign wr_resp = wr_mapped ? RESP_OKAY : RESP_DECERR;

  // read decode looks at the live address, data is caught on accept
  // trade-off: no address register, so araddr must stay put until taken
  assign rd_hit_flags = s_axi_araddr == OFF_TIMER_FLAGS;
  assign rd_hit_en1 = s_axi_araddr == OFF_ENABLE_FIRST;
  assign rd_hit_en2 = s_axi_araddr == OFF_ENABLE_SECOND;
  assign rd_hit_ten = s_axi_araddr == OFF_TIMER_ENABLE;
  assign rd_hit_status = s_axi_araddr == OFF_IRQ_STATUS;
  assign rd_hit_mask = s_axi_araddr == OFF_IRQ_MASK;
  assign rd_mapped = rd_hit_flags | rd_hit_en1 | rd_hit_en2 |
                     rd_hit_ten | rd_hit_status | rd_hit_mask;
  assign rd_resp = rd_mapped ? RESP_OKAY : RESP_DECERR;

  // ****************************************
  // timer event detection
  // ****************************************
  // a match that lingers counts once, on its first cycle
  assign four_match = timer_four_count == timer_four_period;
  assign six_match = timer_six_count == timer_six_period;

  always_ff @(posedge mclk) begin
    if (rst) begin
      four_match_d_r <= 1'b0;
      six_match_d_r <= 1'b0;
    end else if (ce) begin
      four_match_d_r <= four_match;
      six_match_d_r <= six_match;
    end
  end

  // overflow arrives as a one-cycle pulse from the timer
  // a held overflow level would count every cycle, so it must be a pulse
  assign timer_events[TIMER_FOUR_BIT] = four_match & ~four_match_d_r;
  assign timer_events[TIMER_FIVE_BIT] = timer_five_overflow;
  assign timer_events[TIMER_SIX_BIT] = six_match & ~six_match_d_r;

  // ****************************************
  // timer event flag register
  // ****************************************
  // flags set regardless of any enable; only software writes clear them
  event_flag_bank #(
    .W(TFLAG_W),
    .RST_VAL(RST_TIMER_FLAGS)
  ) u_timer_flags (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .ld_en(wr_lane0 & wr_hit_flags),
    .ld_data(wr_data[TFLAG_W-1:0]),
    .clr('0),
    .set(timer_events),
    .q(timer_flags)
  );

  assign timer_six_match_flag = timer_flags[TIMER_SIX_BIT];
  assign timer_five_overflow_flag = timer_flags[TIMER_FIVE_BIT];
  assign timer_four_match_flag = timer_flags[TIMER_FOUR_BIT];

  // ****************************************
  // interrupt status, cleared by reading it
  // ****************************************
  // a read that races an event still leaves that event pending
  assign status_clr = (rd_en & rd_hit_status) ? {TFLAG_W{1'b1}} : '0;

  event_flag_bank #(
    .W(TFLAG_W),
    .RST_VAL(RST_IRQ_STATUS)
  ) u_irq_status (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .ld_en(1'b0),
    .ld_data('0),
    .clr(status_clr),
    .set(timer_events),
    .q(irq_status)
  );

  // ****************************************
  // enable and mask registers
  // ****************************************
  // only bits 6..0 exist in the first enable register
  assign en1_nxt = (wr_lane0 & wr_hit_en1) ? wr_data[EN1_W-1:0] : en1_r;
  assign en2_nxt = (wr_lane0 & wr_hit_en2) ? wr_data[EN2_W-1:0] : en2_r;
  assign ten_nxt = (wr_lane0 & wr_hit_ten) ? wr_data[TFLAG_W-1:0] : ten_r;
  assign mask_nxt = (wr_lane0 & wr_hit_mask) ? wr_data[TFLAG_W-1:0] : mask_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      en1_r <= RST_ENABLE_FIRST;
      en2_r <= RST_ENABLE_SECOND;
      ten_r <= RST_TIMER_ENABLE;
      mask_r <= RST_IRQ_MASK;
    end else if (ce) begin
      en1_r <= en1_nxt;
      en2_r <= en2_nxt;
      ten_r <= ten_nxt;
      mask_r <= mask_nxt;
    end
  end

  // first enable register fields
  assign converter_irq_enable = en1_r[6];
  assign serial_one_receive_enable = en1_r[5];
  assign serial_one_transmit_enable = en1_r[4];
  assign sync_port_one_enable = en1_r[3];
  assign capture_one_enable = en1_r[2];
  assign timer_two_match_enable = en1_r[1];
  assign timer_one_overflow_enable = en1_r[0];

  // second enable register fields
  assign osc_fail_enable = en2_r[7];
  assign comparator_one_enable = en2_r[6];
  assign comparator_two_enable = en2_r[5];
  assign eeprom_write_done_enable = en2_r[4];
  assign bus_collision_one_enable = en2_r[3];
  assign voltage_detect_enable = en2_r[2];
  assign timer_three_overflow_enable = en2_r[1];
  assign capture_two_enable = en2_r[0];

  // ****************************************
  // request gating
  // ****************************************
  // each source flag is paired with its own enable bit
  // enables gate only the request, never the setting of a flag
  assign timer_req = {timer_six_match_flag & ten_r[TIMER_SIX_BIT],
                      timer_five_overflow_flag & ten_r[TIMER_FIVE_BIT],
                      timer_four_match_flag & ten_r[TIMER_FOUR_BIT]};

  assign first_req = first_src_flags & {converter_irq_enable,
                                        serial_one_receive_enable,
                                        serial_one_transmit_enable,
                                        sync_port_one_enable,
                                        capture_one_enable,
                                        timer_two_match_enable,
                                        timer_one_overflow_enable};

  assign second_req = second_src_flags & {osc_fail_enable,
                                          comparator_one_enable,
                                          comparator_two_enable,
                                          eeprom_write_done_enable,
                                          bus_collision_one_enable,
                                          voltage_detect_enable,
                                          timer_three_overflow_enable,
                                          capture_two_enable};

  assign req_any = (|timer_req) | (|first_req) | (|second_req);
  assign irq_any = |(irq_status & mask_r);

  // outputs registered, so they trail the flags by one cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      periph_irq_req <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      periph_irq_req <= req_any;
      irq <= irq_any;
    end
  end

  // ****************************************
  // read data selection
  // ****************************************
  // unstored and unmapped bits read as zero
  assign rd_data = rd_hit_flags ? {{(DATA_W-TFLAG_W){1'b0}}, timer_flags} :
                   rd_hit_en1 ? {{(DATA_W-EN1_W){1'b0}}, en1_r} :
                   rd_hit_en2 ? {{(DATA_W-EN2_W){1'b0}}, en2_r} :
                   rd_hit_ten ? {{(DATA_W-TFLAG_W){1'b0}}, ten_r} :
                   rd_hit_status ? {{(DATA_W-TFLAG_W){1'b0}}, irq_status} :
                   rd_hit_mask ? {{(DATA_W-TFLAG_W){1'b0}}, mask_r} :
                   '0;

endmodule : peripheral_irq_flag_enable_regs

/* verification/irq_regs_properties.sv */
// checker for bus handshakes and register read values
`timescale 1ns/10ps
module irq_regs_checker
  import irq_regs_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic rst, // sync reset
  input wire logic ce, // clock enable
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic [1:0] s_axi_bresp, // b response
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [irq_regs_pkg::ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic [irq_regs_pkg::DATA_W-1:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic periph_irq_req, // peripheral request
  input wire logic irq // status interrupt
);
  // ****************************************
  // helper state
  // ****************************************
  // address of the read in flight, so data can be judged per register
  logic [ADDR_W-1:0] rd_addr_r;
  always_ff @(posedge mclk) begin
    if (s_axi_arvalid && s_axi_arready && ce) rd_addr_r <= s_axi_araddr;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready && ce;
  endsequence
  // ****************************************
  // properties
  // ****************************************
  chk_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  chk_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_read_answer: assert property (rd_taken |=> s_axi_rvalid) else $error("read not answered");
  chk_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  chk_flag_upper_zero: assert property (
    s_axi_rvalid && rd_addr_r == OFF_TIMER_FLAGS |-> s_axi_rdata[31:3] == 29'h0) else $error("flag upper bits set");
  chk_enable_top_zero: assert property (
    s_axi_rvalid && rd_addr_r == OFF_ENABLE_FIRST |-> s_axi_rdata[31:7] == 25'h0) else $error("enable bit 7 set");
  chk_unmapped_read: assert property (s_axi_rvalid && (rd_addr_r > 8'h14 || rd_addr_r[1:0] != 2'h0)
    |-> s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h0) else $error("unmapped read answered");
  chk_reset_quiet: assert property ($fell(rst) |-> !irq && !periph_irq_req && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs busy after reset");
endmodule : irq_regs_checker

bind peripheral_irq_flag_enable_regs irq_regs_checker chk_i (.*);

/* verification/tb.sv */
// self-checking bench for the interrupt flag and enable registers
`timescale 1ns/10ps
module tb;
  import irq_regs_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, ce = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, periph_irq_req, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] timer_four_count = 8'h00, timer_four_period = 8'h25, timer_six_count = 8'h00, timer_six_period = 8'h31;
  logic timer_five_overflow = 1'b0;
  logic [6:0] first_src_flags = 7'h00;
  logic [7:0] second_src_flags = 8'h00;
  int mismatches = 0, compares = 0;
  logic [31:0] d;
  logic [1:0] r;
  peripheral_irq_flag_enable_regs uut (.*);
  always #4 mclk = ~mclk;
  // ****************************************
  // shared tasks
  // ****************************************
  task conclude;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // both channels offered together, each dropped as soon as it is taken
  task wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 20) begin
      mismatches++;
      conclude;
    end
  endtask : wr
  task rd(input logic [7:0] a);
    int n;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 20) begin
      mismatches++;
      conclude;
    end
  endtask : rd
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(d, exp);
  endtask : rdchk
  // let the request and interrupt outputs settle after the last edge
  task settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : settle
  // one-cycle event: 0 four match, 1 five overflow, 2 six match
  task pulse(input int i);
    @(posedge mclk);
    if (i == 0) timer_four_count <= timer_four_period;
    if (i == 1) timer_five_overflow <= 1'b1;
    if (i == 2) timer_six_count <= timer_six_period;
    @(posedge mclk);
    timer_four_count <= 8'h00;
    timer_five_overflow <= 1'b0;
    timer_six_count <= 8'h00;
  endtask : pulse
  // ****************************************
  // scenarios
  // ****************************************
  task t_reset;
    rdchk(OFF_TIMER_FLAGS, 32'h0);
    rdchk(OFF_ENABLE_FIRST, 32'h0);
    rdchk(OFF_ENABLE_SECOND, 32'h0);
    rdchk(8'h40, 32'h0);
    chk(r, RESP_DECERR);
    wr(8'h40, 32'hffffffff);
    chk(r, RESP_DECERR);
    $display("test reset done");
  endtask : t_reset
  task t_access;
    wr(OFF_ENABLE_FIRST, 32'hffffffff);
    rdchk(OFF_ENABLE_FIRST, 32'h7f);
    wr(OFF_ENABLE_FIRST, 32'h2a);
    rdchk(OFF_ENABLE_FIRST, 32'h2a);
    wr(OFF_ENABLE_SECOND, 32'hffffffff);
    rdchk(OFF_ENABLE_SECOND, 32'hff);
    wr(OFF_ENABLE_SECOND, 32'h5a);
    rdchk(OFF_ENABLE_SECOND, 32'h5a);
    s_axi_wstrb <= 4'he;
    wr(OFF_ENABLE_SECOND, 32'h0);
    chk(r, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rdchk(OFF_ENABLE_SECOND, 32'h5a);
    chk(r, RESP_OKAY);
    wr(OFF_TIMER_FLAGS, 32'hffffffff);
    rdchk(OFF_TIMER_FLAGS, 32'h07);
    wr(OFF_TIMER_FLAGS, 32'h0);
    rdchk(OFF_TIMER_FLAGS, 32'h0);
    $display("test access done");
  endtask : t_access
  // each event latches its own bit with the timer enables off, and software clears it
  task t_events;
    for (int i = 0; i < 3; i++) begin
      pulse(i);
      settle(2);
      rdchk(OFF_TIMER_FLAGS, 32'h1 << i);
      rdchk(OFF_TIMER_FLAGS, 32'h1 << i);
      wr(OFF_TIMER_FLAGS, 32'h0);
      rdchk(OFF_TIMER_FLAGS, 32'h0);
    end
    // clock enable low: an overflow pulse must leave no trace
    ce <= 1'b0;
    pulse(1);
    ce <= 1'b1;
    rdchk(OFF_TIMER_FLAGS, 32'h0);
    $display("test events done");
  endtask : t_events
  task t_request;
    wr(OFF_ENABLE_FIRST, 32'h0);
    wr(OFF_ENABLE_SECOND, 32'h0);
    first_src_flags <= 7'h40;
    settle(3);
    chk(periph_irq_req, 1'b0);
    wr(OFF_ENABLE_FIRST, 32'h40);
    settle(2);
    chk(periph_irq_req, 1'b1);
    wr(OFF_ENABLE_FIRST, 32'h0);
    first_src_flags <= 7'h00;
    second_src_flags <= 8'h80;
    wr(OFF_ENABLE_SECOND, 32'h80);
    settle(2);
    chk(periph_irq_req, 1'b1);
    wr(OFF_ENABLE_SECOND, 32'h0);
    second_src_flags <= 8'h00;
    settle(2);
    chk(periph_irq_req, 1'b0);
    pulse(2);
    wr(OFF_TIMER_ENABLE, 32'h4);
    settle(2);
    chk(periph_irq_req, 1'b1);
    wr(OFF_TIMER_FLAGS, 32'h0);
    settle(2);
    chk(periph_irq_req, 1'b0);
    wr(OFF_TIMER_ENABLE, 32'h0);
    $display("test request done");
  endtask : t_request
  // masked event stays quiet, unmasked one raises irq until status is read
  task t_irq;
    rd(OFF_IRQ_STATUS);
    wr(OFF_IRQ_MASK, 32'h2);
    pulse(0);
    settle(2);
    chk(irq, 1'b0);
    pulse(1);
    settle(2);
    chk(irq, 1'b1);
    rdchk(OFF_IRQ_STATUS, 32'h3);
    settle(2);
    chk(irq, 1'b0);
    rdchk(OFF_IRQ_STATUS, 32'h0);
    $display("test irq done");
  endtask : t_irq
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_access;
    t_events;
    t_request;
    t_irq;
    conclude;
  end
endmodule : tb
